/* hdl/sdc_decimator.sv */
// sinc3 decimator with clock source, clock divide and reference controls
`timescale 1ns/1ps
// What this block does
// - each channel's modulator bitstream passes a third-order sinc, ratio sets data rate
// - response is cube of length-N moving sum via three integrators and three combs
// - decimation length equals moving-sum length, nulls at data rate multiples
// - step at input settles within three output data periods
// - after start rises, first sample waits a rate-dependent settling interval
// - clock source pin low selects external clock, high selects internal oscillator
// - internal oscillator: clock pin tri-stated if output bit 0, else drives oscillator
// - external master clock may be 512 kHz or 2.048 MHz, chosen by divide bit
// - clock-divide bit sits at bit 6 of the electrode status register
// - modulator clock is 128 kHz for either master clock
// - clock divide resets to the 512 kHz setting
// - each sample is a 24-bit twos-complement word, most significant bit first
// - codes saturate at 7FFFFF and 800000 instead of wrapping
// - plus one LSB is 000001, zero is 000000, minus one LSB is FFFFFF
// - reference-level bit selects 2.42 V or 4.033 V reference
// - reference buffer power-down bit disables buffer, powered down after reset
// - modulator clock is master clock divided by 4 or 16 per divide bit
// - global data-rate field in first config register sets ratio for all channels
module sdc_decimator #(
  parameter int NCH      = 2,
  parameter int ACC_W    = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              clock_source_pin,
  input  wire logic              osc_clk_en,
  input  wire logic              ext_clk_en,
  output logic                   clk_pin_out,
  output logic                   clk_pin_oe,
  input  wire logic [NCH-1:0]    mod_bit,
  input  wire logic              start_pin,
  output logic                   mod_clk_en,
  output logic      [23:0]       sample_data [NCH],
  output logic                   sample_valid,
  output logic                   high_reference_select,
  output logic                   reference_buffer_powerdown,
  output logic                   use_internal_clock
);
  // decimation ratio per data-rate code: 128k / ratio = 125 .. 8k SPS
  function automatic logic [10:0] ratio_of(input logic [2:0] code);
    case (code)
      3'h0:    ratio_of = 11'h400;
      3'h1:    ratio_of = 11'h200;
      3'h2:    ratio_of = 11'h100;
      3'h3:    ratio_of = 11'h080;
      3'h4:    ratio_of = 11'h040;
      3'h5:    ratio_of = 11'h020;
      3'h6:    ratio_of = 11'h010;
      default: ratio_of = 11'h010;
    endcase
  endfunction
  // log2 of the sinc3 gain (ratio cubed); the output shift maps that gain onto 2^23
  function automatic logic [4:0] shift_of(input logic [2:0] code);
    case (code)
      3'h0:    shift_of = 5'd30;
      3'h1:    shift_of = 5'd27;
      3'h2:    shift_of = 5'd24;
      3'h3:    shift_of = 5'd21;
      3'h4:    shift_of = 5'd18;
      3'h5:    shift_of = 5'd15;
      3'h6:    shift_of = 5'd12;
      default: shift_of = 5'd12;
    endcase
  endfunction

  logic [2:0]  data_rate_field;
  logic        osc_out_bit;
  logic        clock_divide;
  logic        start_reg;
  logic [3:0]  mod_div;
  logic [10:0] dec_cnt;
  logic [1:0]  settle_cnt;
  logic        ready_flag;
  logic        start_q;
  sdc_pkg::sdc_state_e state;
  logic        dec_tick;
  logic        wr_en;
  logic        rd_en;
  logic        go;
  logic        mclk_en;
  logic signed [ACC_W-1:0] integ1 [NCH];
  logic signed [ACC_W-1:0] integ2 [NCH];
  logic signed [ACC_W-1:0] integ3 [NCH];
  logic signed [ACC_W-1:0] comb1_d [NCH];
  logic signed [ACC_W-1:0] comb2_d [NCH];
  logic signed [ACC_W-1:0] comb3_d [NCH];

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign go      = start_reg | start_pin;
  assign dec_tick = mod_clk_en && (dec_cnt == ratio_of(data_rate_field) - 11'd1);

  // clock source selection
  assign use_internal_clock = clock_source_pin;
  assign mclk_en  = clock_source_pin ? osc_clk_en : ext_clk_en;
  assign clk_pin_oe  = clock_source_pin & osc_out_bit;
  assign clk_pin_out = clock_source_pin & osc_out_bit & osc_clk_en;

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_rate_field            <= sdc_pkg::RST_DATA_RATE;
      osc_out_bit                <= sdc_pkg::RST_OSC_OUT_EN;
      high_reference_select      <= sdc_pkg::RST_HIGH_REF;
      reference_buffer_powerdown <= sdc_pkg::RST_REFBUF_PD;
      clock_divide               <= sdc_pkg::RST_CLOCK_DIVIDE;
      start_reg                  <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        sdc_pkg::OFS_FIRST_CONFIG:
          data_rate_field <= pwdata[sdc_pkg::POS_DATA_RATE +: 3];
        sdc_pkg::OFS_SECOND_CONFIG: begin
          osc_out_bit                <= pwdata[sdc_pkg::POS_OSC_OUT_EN];
          high_reference_select      <= pwdata[sdc_pkg::POS_HIGH_REF];
          reference_buffer_powerdown <= pwdata[sdc_pkg::POS_REFBUF_PD];
        end
        sdc_pkg::OFS_ELECTRODE_STAT:
          clock_divide <= pwdata[sdc_pkg::POS_CLOCK_DIVIDE];
        sdc_pkg::OFS_CONTROL:
          start_reg <= pwdata[sdc_pkg::POS_START];
        default: ;
      endcase
    end
  end

  // read mux; reading status clears the ready flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          sdc_pkg::OFS_FIRST_CONFIG:
            prdata[sdc_pkg::POS_DATA_RATE +: 3] <= data_rate_field;
          sdc_pkg::OFS_SECOND_CONFIG: begin
            prdata[sdc_pkg::POS_OSC_OUT_EN] <= osc_out_bit;
            prdata[sdc_pkg::POS_HIGH_REF]   <= high_reference_select;
            prdata[sdc_pkg::POS_REFBUF_PD]  <= reference_buffer_powerdown;
          end
          sdc_pkg::OFS_ELECTRODE_STAT:
            prdata[sdc_pkg::POS_CLOCK_DIVIDE] <= clock_divide;
          sdc_pkg::OFS_CONTROL:  prdata[sdc_pkg::POS_START] <= start_reg;
          sdc_pkg::OFS_STATUS: begin
            prdata[sdc_pkg::POS_RUNNING]        <= (state == sdc_pkg::SDC_RUN);
            prdata[sdc_pkg::POS_SAMPLE_READY]   <= ready_flag;
            prdata[sdc_pkg::POS_CLOCK_INTERNAL] <= clock_source_pin;
          end
          sdc_pkg::OFS_CH0_DATA: prdata[23:0] <= sample_data[0];
          sdc_pkg::OFS_CH1_DATA: prdata[23:0] <= sample_data[NCH-1];
          default: pslverr <= 1'b0;
        endcase
      end
    end
  end

  // modulator clock enable: master / 4 or / 16 gives 128 kHz either way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_div    <= 4'h0;
      mod_clk_en <= 1'b0;
    end else begin
      mod_clk_en <= 1'b0;
      if (mclk_en) begin
        if (mod_div == (clock_divide ? 4'hF : 4'h3)) begin
          mod_div    <= 4'h0;
          mod_clk_en <= 1'b1;
        end else begin
          mod_div <= mod_div + 4'h1;
        end
      end
    end
  end

  // conversion control: restart on start rise, discard settling outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q    <= 1'b0;
      state      <= sdc_pkg::SDC_IDLE;
      dec_cnt    <= 11'h0;
      settle_cnt <= 2'h0;
    end else begin
      start_q <= go;
      case (state)
        sdc_pkg::SDC_IDLE: begin
          if (go && !start_q) begin
            state      <= sdc_pkg::SDC_SETTLE;
            dec_cnt    <= 11'h0;
            settle_cnt <= 2'h0;
          end
        end
        sdc_pkg::SDC_SETTLE, sdc_pkg::SDC_RUN: begin
          if (!go) begin
            state <= sdc_pkg::SDC_IDLE;
          end else if (mod_clk_en) begin
            if (dec_tick) begin
              dec_cnt <= 11'h0;
              if (state == sdc_pkg::SDC_SETTLE) begin
                settle_cnt <= settle_cnt + 2'h1;
                // three full periods flush the cascade before the first sample
                if (settle_cnt == 2'(sdc_pkg::SETTLE_PERIODS - 1)) begin
                  state <= sdc_pkg::SDC_RUN;
                end
              end
            end else begin
              dec_cnt <= dec_cnt + 11'h1;
            end
          end
        end
        default: state <= sdc_pkg::SDC_IDLE;
      endcase
    end
  end

  // cic: three integrators at modulator rate, three combs at output rate
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [ACC_W-1:0] c1;
    logic signed [ACC_W-1:0] c2;
    logic signed [ACC_W-1:0] c3;
    logic signed [ACC_W-1:0] scaled;
    logic signed [ACC_W-1:0] in_val;
    assign in_val = mod_bit[c] ? ACC_W'(1) : -ACC_W'(1);
    // wraparound in the integrators is harmless since combs undo it modulo 2^ACC_W
    assign c1 = integ3[c] - comb1_d[c];
    assign c2 = c1 - comb2_d[c];
    assign c3 = c2 - comb3_d[c];
    // a gain of +-N^3 lands on +-2^23, so an all-ones stream clips and an all-zeros stream lands exactly on 800000
    assign scaled = (shift_of(data_rate_field) >= 5'(sdc_pkg::DATA_WIDTH - 1)) ?
                    (c3 >>> (shift_of(data_rate_field) - 5'(sdc_pkg::DATA_WIDTH - 1))) :
                    (c3 <<< (5'(sdc_pkg::DATA_WIDTH - 1) - shift_of(data_rate_field)));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        integ1[c]  <= '0;
        integ2[c]  <= '0;
        integ3[c]  <= '0;
        comb1_d[c] <= '0;
        comb2_d[c] <= '0;
        comb3_d[c] <= '0;
        sample_data[c] <= 24'h0;
      end else if (state == sdc_pkg::SDC_IDLE) begin
        integ1[c]  <= '0;
        integ2[c]  <= '0;
        integ3[c]  <= '0;
        comb1_d[c] <= '0;
        comb2_d[c] <= '0;
        comb3_d[c] <= '0;
      end else if (mod_clk_en) begin
        integ1[c] <= integ1[c] + in_val;
        integ2[c] <= integ2[c] + integ1[c];
        integ3[c] <= integ3[c] + integ2[c];
        if (dec_tick) begin
          comb1_d[c] <= integ3[c];
          comb2_d[c] <= c1;
          comb3_d[c] <= c2;
          if (state == sdc_pkg::SDC_RUN) begin
            // clip instead of wrap at full scale
            if (scaled > ACC_W'(signed'(sdc_pkg::CODE_POS_FULL)))
              sample_data[c] <= sdc_pkg::CODE_POS_FULL;
            else if (scaled < -ACC_W'(32'sh800000))
              sample_data[c] <= sdc_pkg::CODE_NEG_FULL;
            else
              sample_data[c] <= scaled[23:0];
          end
        end
      end
    end
  end

  // one strobe for all channels together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'b0;
      ready_flag   <= 1'b0;
    end else begin
      sample_valid <= (state == sdc_pkg::SDC_RUN) && dec_tick && go;
      if ((state == sdc_pkg::SDC_RUN) && dec_tick && go)
        ready_flag <= 1'b1;
      else if (rd_en && paddr == sdc_pkg::OFS_STATUS)
        ready_flag <= 1'b0;
    end
  end
endmodule

/* common/sdc_pkg.sv */
// shared constants for the sinc3 decimator and clock/format block
package sdc_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_FIRST_CONFIG    = 8'h04;
  localparam logic [7:0]  OFS_SECOND_CONFIG   = 8'h08;
  localparam logic [7:0]  OFS_ELECTRODE_STAT  = 8'h0C;
  localparam logic [7:0]  OFS_CONTROL         = 8'h10;
  localparam logic [7:0]  OFS_STATUS          = 8'h14;
  localparam logic [7:0]  OFS_CH0_DATA        = 8'h18;
  localparam logic [7:0]  OFS_CH1_DATA        = 8'h1C;
  // field positions
  localparam int          POS_DATA_RATE       = 0;
  localparam int          POS_OSC_OUT_EN      = 3;
  localparam int          POS_HIGH_REF        = 4;
  localparam int          POS_REFBUF_PD       = 7;
  localparam int          POS_CLOCK_DIVIDE    = 6;
  localparam int          POS_START           = 0;
  localparam int          POS_RUNNING         = 0;
  localparam int          POS_SAMPLE_READY    = 1;
  localparam int          POS_CLOCK_INTERNAL  = 2;
  // reset values
  localparam logic [2:0]  RST_DATA_RATE       = 3'h2;
  localparam logic        RST_OSC_OUT_EN      = 1'b0;
  localparam logic        RST_HIGH_REF        = 1'b0;
  localparam logic        RST_REFBUF_PD       = 1'b1;
  localparam logic        RST_CLOCK_DIVIDE    = 1'b0;
  // timing
  localparam int          MOD_RATE_HZ         = 128000;
  localparam int          DIV_SLOW_MCLK       = 4;
  localparam int          DIV_FAST_MCLK       = 16;
  localparam int          SETTLE_PERIODS      = 3;
  localparam int          DATA_WIDTH          = 24;
  // output code limits
  localparam logic [23:0] CODE_POS_FULL       = 24'h7FFFFF;
  localparam logic [23:0] CODE_NEG_FULL       = 24'h800000;
  typedef enum logic [1:0] {SDC_IDLE, SDC_SETTLE, SDC_RUN} sdc_state_e;
endpackage

/* testbench/sdc_decimator_sva.sv */
// concurrent checks on the decimator's ports
`timescale 1ns/1ps
module sdc_decimator_sva #(
  parameter int NCH = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clock_source_pin,
  input wire logic        osc_clk_en,
  input wire logic        clk_pin_out,
  input wire logic        clk_pin_oe,
  input wire logic        mod_clk_en,
  input wire logic [23:0] sample_data [NCH],
  input wire logic        sample_valid,
  input wire logic        reference_buffer_powerdown,
  input wire logic        use_internal_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_mod_quiet;
    !mod_clk_en [*3];
  endsequence
  // source high this cycle and the two before, so a tick cannot come from the other clock
  sequence s_osc_steady;
    clock_source_pin && $past(clock_source_pin) && $past(clock_source_pin, 2);
  endsequence
  a_modclk_gap: assert property (mod_clk_en |=> s_mod_quiet)
    else $error("modulator ticks closer than four master ticks");
  a_modclk_cause: assert property (s_osc_steady ##0 mod_clk_en |-> $past(osc_clk_en))
    else $error("modulator tick without oscillator tick");
  a_apb_answer: assert property (psel && penable |-> pready && !pslverr)
    else $error("access phase not answered cleanly");
  a_valid_single: assert property (sample_valid |=> !sample_valid)
    else $error("sample strobe longer than one cycle");
  a_valid_held: assert property (sample_valid |=> $stable(sample_data[0]) && $stable(sample_data[NCH-1]))
    else $error("sample words moved during strobe");
  a_oe_source: assert property (clk_pin_oe |-> clock_source_pin)
    else $error("clock pin driven while external clock selected");
  a_pin_drives: assert property (clk_pin_oe |-> clk_pin_out == osc_clk_en)
    else $error("clock pin does not carry oscillator");
  a_source_follow: assert property (use_internal_clock == clock_source_pin)
    else $error("clock source does not follow pin");
  a_refbuf_reset: assert property ($rose(presetn) |-> reference_buffer_powerdown)
    else $error("reference buffer not powered down after reset");
endmodule

/* testbench/sdc_modulator_model.sv */
// far-side model: master clock ticks and modulator bitstream
`timescale 1ns/1ps
module sdc_modulator_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       mod_clk_en,
  input  wire logic [1:0] bit_level,
  output logic            osc_clk_en,
  output logic            ext_clk_en,
  output logic [1:0]      mod_bit
);
  logic [2:0] tick_cnt;
  // tick rates scaled far above real clocks to keep the run short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 3'h0;
    end else begin
      tick_cnt <= tick_cnt + 3'h1;
    end
  end
  assign osc_clk_en = tick_cnt[0];
  assign ext_clk_en = (tick_cnt == 3'h7);
  // new bit only on a modulator tick, as the analog loop would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_bit <= 2'h0;
    end else if (mod_clk_en) begin
      mod_bit <= bit_level;
    end
  end
endmodule

/* testbench/tb_top.sv */
// testbench for the sinc3 decimator block
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, clock_source_pin;
  logic        start_pin, clk_pin_out, clk_pin_oe, mod_clk_en, sample_valid, osc_clk_en;
  logic        ext_clk_en, high_reference_select, reference_buffer_powerdown, use_internal_clock;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  mod_bit, bit_level;
  logic [23:0] sample_data [2];
  int          err_total, checks;
  sdc_decimator i_sdc_decimator (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_source_pin(clock_source_pin), .osc_clk_en(osc_clk_en),
    .ext_clk_en(ext_clk_en), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .mod_bit(mod_bit), .start_pin(start_pin), .mod_clk_en(mod_clk_en),
    .sample_data(sample_data), .sample_valid(sample_valid),
    .high_reference_select(high_reference_select),
    .reference_buffer_powerdown(reference_buffer_powerdown),
    .use_internal_clock(use_internal_clock));
  sdc_modulator_model i_sdc_modulator_model (.pclk(pclk), .presetn(presetn),
    .mod_clk_en(mod_clk_en), .bit_level(bit_level), .osc_clk_en(osc_clk_en),
    .ext_clk_en(ext_clk_en), .mod_bit(mod_bit));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // host side paces register access by the bus clock, never faster
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check(1'b0, "bus timeout");
      end_of_test();
    end
  endtask
  // bounded wait for the sample strobe, sampled mid-cycle where outputs are settled
  task automatic wait_valid(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (sample_valid !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      check(1'b0, "no sample");
      end_of_test();
    end
  endtask
  task automatic t_reset;
    apb(1'b0, sdc_pkg::OFS_FIRST_CONFIG, 32'h0);
    check(rd[2:0] === 3'h2, "rate reset");
    apb(1'b0, sdc_pkg::OFS_SECOND_CONFIG, 32'h0);
    check({rd[7], rd[4], rd[3]} === 3'b100, "config reset");
    apb(1'b0, sdc_pkg::OFS_ELECTRODE_STAT, 32'h0);
    check(rd[6] === 1'b0, "divide reset");
    apb(1'b0, 8'h3C, 32'h0);
    check(rd === 32'h0, "unmapped read");
    check(reference_buffer_powerdown === 1'b1, "buffer reset");
    $display("reset test done");
  endtask
  task automatic t_refs;
    apb(1'b1, sdc_pkg::OFS_SECOND_CONFIG, 32'h10);
    @(negedge pclk);
    check(high_reference_select === 1'b1 && reference_buffer_powerdown === 1'b0, "ref on");
    apb(1'b1, sdc_pkg::OFS_SECOND_CONFIG, 32'h80);
    @(negedge pclk);
    check(high_reference_select === 1'b0 && reference_buffer_powerdown === 1'b1, "ref off");
    apb(1'b1, 8'h3C, 32'hFFFFFFFF);
    apb(1'b0, 8'h3C, 32'h0);
    check(rd === 32'h0, "unmapped write");
    $display("reference test done");
  endtask
  task automatic t_clock;
    for (int i = 0; i < 4; i++) begin
      clock_source_pin <= i[1];
      apb(1'b1, sdc_pkg::OFS_SECOND_CONFIG, {28'h0, i[0], 3'h0});
      @(negedge pclk);
      check(use_internal_clock === i[1], "source select");
      check(clk_pin_oe === (i[1] & i[0]), "clock pin drive");
    end
    $display("clock source test done");
  endtask
  task automatic t_divide;
    int n, exp;
    for (int i = 0; i < 4; i++) begin
      clock_source_pin <= ~i[1];
      apb(1'b1, sdc_pkg::OFS_ELECTRODE_STAT, {25'h0, i[0], 6'h0});
      apb(1'b0, sdc_pkg::OFS_ELECTRODE_STAT, 32'h0);
      check(rd[6] === i[0], "divide readback");
      repeat (64) @(negedge pclk);
      n = 0;
      repeat (640) begin
        @(negedge pclk);
        n += int'(mod_clk_en === 1'b1);
      end
      exp = 640 / ((i[1] ? 8 : 2) * (i[0] ? 16 : 4));
      check(n >= exp - 1 && n <= exp + 1, "modulator tick rate");
    end
    clock_source_pin <= 1'b1;
    apb(1'b1, sdc_pkg::OFS_ELECTRODE_STAT, 32'h0);
    $display("divide test done");
  endtask
  // ch0 fed all ones, ch1 all zeros; the filter is started by register or by pin
  task automatic t_data(input int code, input logic by_pin);
    int per, gap;
    logic [23:0] last;
    per = (1024 >> code) * 8;
    bit_level <= 2'b01;
    apb(1'b1, sdc_pkg::OFS_FIRST_CONFIG, 32'(code));
    if (by_pin) begin
      start_pin <= 1'b1;
    end else begin
      apb(1'b1, sdc_pkg::OFS_CONTROL, 32'h1);
    end
    wait_valid(gap);
    check(gap > 2 * per && gap <= 5 * per, "first sample latency");
    wait_valid(gap);
    last = sample_data[0];
    wait_valid(gap);
    check(gap === per, "output period");
    check(sample_data[0] === last, "settled value");
    check(sample_data[0] === sdc_pkg::CODE_POS_FULL && sample_data[1] === sdc_pkg::CODE_NEG_FULL, "full scale codes");
    if (by_pin) begin
      start_pin <= 1'b0;
    end else begin
      apb(1'b1, sdc_pkg::OFS_CONTROL, 32'h0);
    end
    repeat (4) @(negedge pclk);
    $display("data test done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clock_source_pin = 1'b1;
    start_pin = 1'b0;
    bit_level = 2'h0;
    err_total = 0;
    checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refs();
    t_clock();
    t_divide();
    t_data(6, 1'b0);
    t_data(5, 1'b1);
    end_of_test();
  end
endmodule
bind sdc_decimator sdc_decimator_sva #(.NCH(NCH)) i_sdc_decimator_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .clock_source_pin(clock_source_pin), .osc_clk_en(osc_clk_en), .clk_pin_out(clk_pin_out),
  .clk_pin_oe(clk_pin_oe), .mod_clk_en(mod_clk_en), .sample_data(sample_data),
  .sample_valid(sample_valid), .reference_buffer_powerdown(reference_buffer_powerdown),
  .use_internal_clock(use_internal_clock));
